// File: verilog/irfe_defs.vh
// Purpose: constants for the infrared front end
// Assumes: 100 MHz pclk, 32-bit APB words
// Notes:   offsets are byte addresses
`ifndef IRFE_DEFS_VH
`define IRFE_DEFS_VH
// ***************************
// register offsets
// ***************************
`define OFF_CFG     12'h000
`define OFF_MODE    12'h004
`define OFF_BITDIV  12'h008
`define OFF_CIRDIV  12'h00c
`define OFF_HDTO    12'h010
`define OFF_TXDATA  12'h014
`define OFF_RXDATA  12'h018
`define OFF_STATUS  12'h01c
`define OFF_UBASE   12'h020
`define OFF_FBASE   12'h024
// ***************************
// field positions
// ***************************
`define CFG_FAST    0
`define CFG_HDX     1
`define CFG_TTYPE   4
// ***************************
// reset values
// ***************************
`define RST_CFG     8'h00
`define RST_MODE    3'h0
`define RST_BITDIV  20'h00364
`define RST_CIRDIV  16'h0524
`define RST_HDTO    8'h00
`define RST_BASE    16'h0000
// ***************************
// format codes
// ***************************
`define MODE_SIR    3'h0
`define MODE_ASK    3'h1
`define MODE_F576   3'h2
`define MODE_F1152  3'h3
`define MODE_F4M    3'h4
`define MODE_CIR    3'h5
// ***************************
// timing
// ***************************
`define CLK_HZ        100000000
`define ASK_CAR_HZ    500000
`define ASK_HALF      (`CLK_HZ / (2 * `ASK_CAR_HZ))
`define HD_STEP_US    100
`define HD_STEP_CYC   ((`CLK_HZ / 1000000) * `HD_STEP_US)
`define FIR_PKT_BITS  2048
`endif

// File: verilog/infrared_port_front_end.v
// Purpose: infrared symbol encoder/decoder, pin routing and turnaround timer
// Assumes: synchronous inputs, pulse-active-high transceiver signals
// Notes:   zero-wait APB slave with one registered read stage
// How it works
// - slow pulse: async LSB first, zero start
// - slow pulse: zero bit is early pulse
// - fast: sync LSB first, packets to 2048 bits
// - fast low rates use pulse-style encoding
// - top fast rate uses pulse position modulation
// - carrier-keyed: async LSB first, zero start
// - carrier-keyed: zero bit is 500 kHz carrier
// - remote-control amplitude keyed encoder/decoder
// - remote carrier programmable 6.25 kHz-1.6 MHz
// - remote bit cell programmable 390 Hz-100 kHz
// - config bit 4 sets shared pin role
// - fast bit picks fast or slow receiver
// - both paths take shared pin when both set
// - slow formats use second uart base register
// - fast formats use own base register
// - half duplex: timer blocks direction change
// - new data in direction restarts timer
// - start bit during timeout: restart after char
// - timeout 0 to 25.5 ms, 100 us steps
`timescale 1ns/1ps
`include "irfe_defs.vh"
module infrared_port_front_end #(
   parameter HD_TICK = `HD_STEP_CYC
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output wire        pslverr,
   output wire [31:0] prdata,
   input  wire        primary_ir_rx_input,
   input  wire        secondary_ir_rx_input,
   input  wire        shared_pin_in,
   output wire        shared_pin_out,
   output wire        shared_pin_oe,
   output wire        ir_tx_output
);

   // ***************************
   // helpers
   // ***************************
   // units in one character for a format
   function [4:0] units;
      input [2:0] m;
      begin
         case (m)
            `MODE_SIR, `MODE_ASK: units = 5'd10;
            `MODE_F4M:            units = 5'd16;
            default:              units = 5'd8;
         endcase
      end
   endfunction
   // async formats carry start and stop cells
   function is_async;
      input [2:0] m;
      begin
         is_async = (m == `MODE_SIR) || (m == `MODE_ASK);
      end
   endfunction
   // pulse position in four chips back to two bits; earliest lit chip of 1 to 3 wins, chip 0 only when none of them is lit
   function [1:0] ppm_sym;
      input [3:0] c;
      begin
         ppm_sym = c[1] ? 2'd1 : c[2] ? 2'd2 : c[3] ? 2'd3 : 2'd0;
      end
   endfunction

   // ***************************
   // registers
   // ***************************
   reg  [7:0]  cfg_q;
   reg  [2:0]  mode_q;
   reg  [19:0] bitdiv_q;
   reg  [15:0] cirdiv_q;
   reg  [7:0]  hdto_q;
   reg  [15:0] ubase_q;
   reg  [15:0] fbase_q;
   reg  [7:0]  txbuf_q;
   reg         txpend_q;
   reg  [7:0]  rxbuf_q;
   reg         rxval_q;
   reg         ovr_q;
   reg         pkterr_q;
   reg  [31:0] prdata_q;
   reg         tx_busy_q;
   reg  [4:0]  tx_idx_q;
   reg  [19:0] tx_cnt_q;
   reg  [9:0]  tx_frm_q;
   reg  [11:0] pkt_q;
   reg         rx_busy_q;
   reg  [4:0]  rx_idx_q;
   reg  [19:0] rx_cnt_q;
   reg         rx_seen_q;
   reg  [15:0] rx_bits_q;
   reg  [15:0] car_cnt_q;
   reg         car_q;
   reg  [7:0]  hd_q;
   reg  [15:0] tick_q;
   reg         dir_tx_q;

   wire fast  = cfg_q[`CFG_FAST];
   wire hdx   = cfg_q[`CFG_HDX];
   wire ttype = cfg_q[`CFG_TTYPE];

   // ***************************
   // pin routing
   // ***************************
   // shared pin drives rate mode or acts as a second fast input
   assign shared_pin_oe  = ~ttype;
   assign shared_pin_out = fast;
   // both paths move to the shared pin only when both bits are set
   wire receive_path_one = (fast & ttype) ? shared_pin_in : primary_ir_rx_input;
   wire receive_path_two = (fast & ttype) ? shared_pin_in : secondary_ir_rx_input;
   // fast receiver listens on path two, slow receiver on path one
   wire rx_pin = fast ? receive_path_two : receive_path_one;

   // ***************************
   // apb decode
   // ***************************
   wire        acc   = psel & penable;
   wire        wr    = acc & pwrite;
   wire        rd    = acc & ~pwrite;
   wire [11:0] a     = {paddr[11:2], 2'b00};
   wire        hit   = (a <= `OFF_FBASE);
   wire [31:0] stat  = {24'h0, pkterr_q, (hd_q != 8'h00), dir_tx_q, ovr_q, rxval_q,
                        rx_busy_q, txpend_q, tx_busy_q};
   reg  [31:0] rmux;
   assign pready  = 1'b1;
   assign pslverr = acc & ~hit;
   assign prdata  = prdata_q;
   // read mux, sampled in the setup cycle so data leaves a flop
   always @* begin
      rmux = 32'h0;
      case (a)
         `OFF_CFG:    rmux = {24'h0, cfg_q};
         `OFF_MODE:   rmux = {29'h0, mode_q};
         `OFF_BITDIV: rmux = {12'h0, bitdiv_q};
         `OFF_CIRDIV: rmux = {16'h0, cirdiv_q};
         `OFF_HDTO:   rmux = {24'h0, hdto_q};
         `OFF_TXDATA: rmux = {24'h0, txbuf_q};
         `OFF_RXDATA: rmux = {24'h0, rxbuf_q};
         `OFF_STATUS: rmux = stat;
         `OFF_UBASE:  rmux = {16'h0, ubase_q};
         `OFF_FBASE:  rmux = {16'h0, fbase_q};
         default:     rmux = 32'h0;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata_q <= 32'h0;
      else if (psel & ~penable)
         prdata_q <= rmux;
   end

   // ***************************
   // carrier generator
   // ***************************
   // remote carrier half period is software set, carrier-keyed is fixed
   wire [31:0] ask_half = `ASK_HALF;
   wire [15:0] car_half = (mode_q == `MODE_CIR) ? cirdiv_q : ask_half[15:0];
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         car_cnt_q <= 16'h0;
         car_q     <= 1'b0;
      end else if (car_cnt_q + 16'h1 >= car_half) begin
         car_cnt_q <= 16'h0;
         car_q     <= ~car_q;
      end else begin
         car_cnt_q <= car_cnt_q + 16'h1;
      end
   end

   // ***************************
   // turnaround gate
   // ***************************
   wire tx_unit_end = tx_busy_q & (tx_cnt_q + 20'h1 >= bitdiv_q);
   wire rx_unit_end = rx_busy_q & (rx_cnt_q + 20'h1 >= bitdiv_q);
   wire tx_last     = tx_unit_end & (tx_idx_q + 5'h1 == units(mode_q));
   wire rx_last     = rx_unit_end & (rx_idx_q + 5'h1 == units(mode_q));
   wire hd_idle     = (hd_q == 8'h00);
   // no direction change while the timer runs
   wire tx_ok = ~hdx | (dir_tx_q & ~rx_busy_q) | (hd_idle & ~rx_busy_q);
   wire rx_ok = ~hdx | ~dir_tx_q | (hd_idle & ~tx_busy_q);
   wire fir   = (mode_q == `MODE_F576) | (mode_q == `MODE_F1152) | (mode_q == `MODE_F4M);
   wire pkt_full = fir & (pkt_q + 12'd8 > `FIR_PKT_BITS);
   wire tx_go = txpend_q & ~tx_busy_q & tx_ok & ~pkt_full;
   wire rx_go = ~rx_busy_q & rx_pin & rx_ok;

   // timer reloads on every bit moved; frozen while a character is in flight
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hd_q     <= 8'h00;
         tick_q   <= 16'h0;
         dir_tx_q <= 1'b0;
      end else begin
         if (tx_go)
            dir_tx_q <= 1'b1;
         else if (rx_go)
            dir_tx_q <= 1'b0;
         if (!hdx) begin
            hd_q   <= 8'h00;
            tick_q <= 16'h0;
         end else if (tx_unit_end | rx_unit_end) begin
            hd_q   <= hdto_q;
            tick_q <= 16'h0;
         end else if (tx_busy_q | rx_busy_q) begin
            tick_q <= 16'h0;
         end else if (!hd_idle) begin
            if (tick_q + 16'h1 >= HD_TICK[15:0]) begin
               tick_q <= 16'h0;
               hd_q   <= hd_q - 8'h01;
            end else begin
               tick_q <= tick_q + 16'h1;
            end
         end
      end
   end

   // ***************************
   // software registers
   // ***************************
   // base registers only steer address decode outside this block
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q    <= `RST_CFG;
         mode_q   <= `RST_MODE;
         bitdiv_q <= `RST_BITDIV;
         cirdiv_q <= `RST_CIRDIV;
         hdto_q   <= `RST_HDTO;
         ubase_q  <= `RST_BASE;
         fbase_q  <= `RST_BASE;
         txbuf_q  <= 8'h00;
         txpend_q <= 1'b0;
         pkterr_q <= 1'b0;
      end else begin
         if (wr && a == `OFF_CFG)
            cfg_q <= pwdata[7:0];
         if (wr && a == `OFF_MODE)
            mode_q <= pwdata[2:0];
         if (wr && a == `OFF_BITDIV)
            bitdiv_q <= pwdata[19:0];
         if (wr && a == `OFF_CIRDIV)
            cirdiv_q <= pwdata[15:0];
         if (wr && a == `OFF_HDTO)
            hdto_q <= pwdata[7:0];
         if (wr && a == `OFF_UBASE)
            ubase_q <= pwdata[15:0];
         if (wr && a == `OFF_FBASE)
            fbase_q <= pwdata[15:0];
         // a byte held back by busy or turnaround waits here until the gate opens; one that would overfill the packet is dropped
         if (wr && a == `OFF_TXDATA && (!txpend_q || tx_go)) begin
            txbuf_q  <= pwdata[7:0];
            txpend_q <= 1'b1;
         end else if (tx_go) begin
            txpend_q <= 1'b0;
         end else if (txpend_q && pkt_full) begin
            txpend_q <= 1'b0;
         end
         // error wins over a clearing write in the same cycle
         if (txpend_q && pkt_full && !tx_busy_q)
            pkterr_q <= 1'b1;
         else if (wr && a == `OFF_STATUS && pwdata[7])
            pkterr_q <= 1'b0;
      end
   end

   // ***************************
   // transmitter
   // ***************************
   wire       tx_bit  = tx_frm_q[tx_idx_q[3:0]];
   wire [1:0] tx_sym  = tx_frm_q[{tx_idx_q[3:2], 1'b0} +: 2];
   wire       early   = (tx_cnt_q < {2'b00, bitdiv_q[19:2]});
   reg        tx_lvl;

   // symbol shaping per format
   always @* begin
      tx_lvl = 1'b0;
      if (tx_busy_q) begin
         case (mode_q)
            `MODE_SIR:   tx_lvl = ~tx_bit & early;
            `MODE_F576:  tx_lvl = ~tx_bit & early;
            `MODE_F1152: tx_lvl = ~tx_bit & early;
            `MODE_ASK:   tx_lvl = ~tx_bit & car_q;
            `MODE_F4M:   tx_lvl = (tx_idx_q[1:0] == tx_sym);
            `MODE_CIR:   tx_lvl = tx_bit & car_q;
            default:     tx_lvl = 1'b0;
         endcase
      end
   end
   reg tx_out_q;
   assign ir_tx_output = tx_out_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_busy_q <= 1'b0;
         tx_idx_q  <= 5'h0;
         tx_cnt_q  <= 20'h0;
         tx_frm_q  <= 10'h3ff;
         tx_out_q  <= 1'b0;
         pkt_q     <= 12'h0;
      end else begin
         tx_out_q <= tx_lvl;
         if (tx_go) begin
            tx_busy_q <= 1'b1;
            tx_idx_q  <= 5'h0;
            tx_cnt_q  <= 20'h0;
            // async gets a zero start and a stop; LSB goes first
            if (is_async(mode_q))
               tx_frm_q <= {1'b1, txbuf_q, 1'b0};
            else
               tx_frm_q <= {2'b11, txbuf_q};
            if (fir)
               pkt_q <= pkt_q + 12'd8;
         end else if (tx_busy_q) begin
            if (tx_last) begin
               tx_busy_q <= 1'b0;
               tx_cnt_q  <= 20'h0;
            end else if (tx_unit_end) begin
               tx_idx_q <= tx_idx_q + 5'h1;
               tx_cnt_q <= 20'h0;
            end else begin
               tx_cnt_q <= tx_cnt_q + 20'h1;
            end
         end else if (!txpend_q) begin
            pkt_q <= 12'h0;  // packet ends when the stream runs dry
         end
      end
   end

   // ***************************
   // receiver
   // ***************************
   // the sample at a cell's closing edge already belongs to the next cell
   wire [15:0] bits_n = rx_bits_q | ({15'h0, rx_seen_q} << rx_idx_q[3:0]);
   reg  [7:0]  rx_byte;
   // a pulse or carrier burst inside a cell marks the cell
   always @* begin
      case (mode_q)
         `MODE_SIR, `MODE_ASK: rx_byte = ~bits_n[8:1];
         `MODE_F4M: rx_byte = {ppm_sym(bits_n[15:12]), ppm_sym(bits_n[11:8]),
                               ppm_sym(bits_n[7:4]), ppm_sym(bits_n[3:0])};
         `MODE_CIR: rx_byte = bits_n[7:0];
         default:   rx_byte = ~bits_n[7:0];
      endcase
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_busy_q <= 1'b0;
         rx_idx_q  <= 5'h0;
         rx_cnt_q  <= 20'h0;
         rx_seen_q <= 1'b0;
         rx_bits_q <= 16'h0;
         rxbuf_q   <= 8'h00;
         rxval_q   <= 1'b0;
         ovr_q     <= 1'b0;
      end else begin
         if (rx_go) begin
            rx_busy_q <= 1'b1;
            rx_idx_q  <= 5'h0;
            rx_cnt_q  <= 20'h0;
            rx_seen_q <= 1'b1;
            rx_bits_q <= 16'h0;
         end else if (rx_busy_q) begin
            if (rx_unit_end) begin
               rx_bits_q <= bits_n;
               rx_idx_q  <= rx_idx_q + 5'h1;
               rx_cnt_q  <= 20'h0;
               rx_seen_q <= rx_pin;
               if (rx_last)
                  rx_busy_q <= 1'b0;
            end else begin
               rx_cnt_q  <= rx_cnt_q + 20'h1;
               rx_seen_q <= rx_seen_q | rx_pin;
            end
         end
         // a completed byte wins over a read in the same cycle
         if (rx_last) begin
            rxbuf_q <= rx_byte;
            rxval_q <= 1'b1;
            if (rxval_q && !(rd && a == `OFF_RXDATA))
               ovr_q <= 1'b1;
         end else if (rd && a == `OFF_RXDATA) begin
            rxval_q <= 1'b0;
            ovr_q   <= 1'b0;
         end
      end
   end
endmodule

// File: tb/irfe_chk.sv
// Purpose: port-level checks for the infrared front end
// Assumes: one pclk domain, async active-low presetn
// Notes:   sees only the top module's ports
`timescale 1ns/1ps
module irfe_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [31:0] prdata,
   input wire logic        shared_pin_out,
   input wire logic        shared_pin_oe
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ***************************
   // bus and shared pin checks
   // ***************************
   // config write in its access phase
   wire cfg_wr = psel && penable && pwrite && paddr[11:2] == 10'h000;
   wire acc    = psel && penable;
   property p_ready; psel |-> pready; endproperty
   a_ready: assert property (p_ready) else $error("pready low during transfer");
   property p_err_hi; acc && paddr > 12'h027 |-> pslverr; endproperty
   a_err_hi: assert property (p_err_hi) else $error("unmapped access not refused");
   property p_err_lo; acc && paddr <= 12'h024 |-> !pslverr; endproperty
   a_err_lo: assert property (p_err_lo) else $error("mapped access refused");
   property p_rd_zero; acc && !pwrite && paddr > 12'h027 |-> prdata == 32'h0; endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("unmapped read not zero");
   property p_oe_hold; !cfg_wr |=> $stable(shared_pin_oe); endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("pin role moved without write");
   property p_oe_follow; cfg_wr |=> shared_pin_oe == !$past(pwdata[4]); endproperty
   a_oe_follow: assert property (p_oe_follow) else $error("pin role wrong");
   property p_out_hold; !cfg_wr |=> $stable(shared_pin_out); endproperty
   a_out_hold: assert property (p_out_hold) else $error("rate mode moved");
   property p_out_follow; cfg_wr |=> shared_pin_out == $past(pwdata[0]); endproperty
   a_out_follow: assert property (p_out_follow) else $error("rate mode wrong");
endmodule

// File: tb/ir_xcvr_model.sv
// Purpose: external infrared transceiver, receive side
// Assumes: pulse-active-high receive lines, idle dark
// Notes:   a dark line reads low, as a real detector does
`timescale 1ns/1ps
module ir_xcvr_model (
   input  wire logic pclk,
   output logic      rx_slow,
   output logic      rx_fast,
   output logic      rx_alt
);
   initial {rx_slow, rx_fast, rx_alt} = 3'b000;
   // ***************************
   // symbol sender
   // ***************************
   // zero bit = pulse for first quarter of the unit, one bit = dark
   task automatic send(input int ln, input logic [9:0] bits, input int nb, input int unit);
      int   i;
      int   c;
      logic v;
      for (i = 0; i < nb; i++) begin
         for (c = 0; c < unit; c++) begin
            @(posedge pclk);
            v = !bits[i] && c < unit / 4;
            case (ln)
               0: rx_slow <= v;
               1: rx_fast <= v;
               default: rx_alt <= v;
            endcase
         end
      end
      @(posedge pclk);
      {rx_slow, rx_fast, rx_alt} <= 3'b000;
   endtask
endmodule

// File: tb/test_infrared_port_front_end.sv
// Purpose: self-checking bench for the infrared front end
// Assumes: short turnaround tick, small bit divisors
// Notes:   expected receive bytes kept in a queue
`timescale 1ns/1ps
`include "irfe_defs.vh"
module test_infrared_port_front_end;
   logic        pclk, presetn, psel, penable, pwrite, err, m;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd, wv;
   logic [7:0]  b, got;
   wire         pready, pslverr, shared_pin_out, shared_pin_oe, ir_tx_output;
   wire  [31:0] prdata;
   wire         rx_a, rx_b, alt_drv, shared_pin;
   int          n_fail, check_count, i, run, k, u, cur;
   logic [7:0]  exp_q[$];
   logic [11:0] ra[7] = '{`OFF_CFG, `OFF_MODE, `OFF_BITDIV, `OFF_CIRDIV, `OFF_HDTO, `OFF_UBASE, `OFF_FBASE};
   logic [31:0] rv[7] = '{`RST_CFG, `RST_MODE, `RST_BITDIV, `RST_CIRDIV, `RST_HDTO, `RST_BASE, `RST_BASE};
   logic [31:0] rm[7] = '{32'h13, 32'h3, 32'hfffff, 32'hffff, 32'hff, 32'hffff, 32'hffff};
   // released shared pin carries the model's third receive line, rx_alt
   assign shared_pin = shared_pin_oe ? shared_pin_out : alt_drv;
   infrared_port_front_end #(.HD_TICK(10)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .primary_ir_rx_input(rx_a), .secondary_ir_rx_input(rx_b),
      .shared_pin_in(shared_pin), .shared_pin_out(shared_pin_out), .shared_pin_oe(shared_pin_oe),
      .ir_tx_output(ir_tx_output));
   ir_xcvr_model xcvr (.pclk(pclk), .rx_slow(rx_a), .rx_fast(rx_b), .rx_alt(alt_drv));
   // ***************************
   // tasks
   // ***************************
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      check_count++;
      if (s !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   // one apb transfer; an idle edge first so psel is never set twice in a step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         n_fail++;
         close_out();
      end
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // decode start plus 8 units; light inside a cell's window is a zero
   // carrier may be dark when a frame starts, so windows skip up to one carrier half
   task automatic txcap(input int unit, input int skip);
      int c;
      k = 0;
      while (ir_tx_output !== 1'b1 && k < 5000) begin
         @(negedge pclk);
         k++;
      end
      if (k >= 5000) begin
         n_fail++;
         close_out();
      end
      run = 0;
      cur = 0;
      for (i = 0; i < 9; i++) begin
         m = 0;
         for (c = 0; c < unit; c++) begin
            if (c >= skip && c < skip + unit / 2)
               m = m | ir_tx_output;
            cur = (ir_tx_output === 1'b1) ? cur + 1 : 0;
            if (i == 0 && cur > run)
               run = cur;
            @(negedge pclk);
         end
         if (i > 0)
            got[i-1] = !m;
      end
   endtask
   // ***************************
   // clock and main sequence
   // ***************************
   initial begin
      pclk = 0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      n_fail = 0;
      check_count = 0;
      void'($urandom(54855));
      repeat (3) @(posedge pclk);
      presetn <= 1;
      for (u = 0; u < 7; u++) begin
         apb(0, ra[u], 0);
         chk("reset_value", rv[u], rd);
         wv = $urandom & rm[u];
         apb(1, ra[u], wv);
         apb(0, ra[u], 0);
         chk("readback", wv, rd);
         apb(1, ra[u], rv[u]);
      end
      apb(0, 12'h028, 0);
      chk("unmapped_err", 1, err);
      chk("unmapped_rd", 0, rd);
      $display("test registers done");
      apb(1, `OFF_CFG, 32'h01);
      @(negedge pclk);
      chk("rate_mode", 1, shared_pin_out);
      apb(1, `OFF_CFG, 32'h10);
      @(negedge pclk);
      chk("pin_oe", 0, shared_pin_oe);
      $display("test pins done");
      apb(1, `OFF_BITDIV, 16);
      for (u = 0; u < 3; u++) begin
         apb(1, `OFF_CFG, u == 0 ? 32'h0 : u == 1 ? 32'h1 : 32'h11);
         apb(1, `OFF_MODE, u == 0 ? `MODE_SIR : u == 1 ? `MODE_F576 : `MODE_F1152);
         b = $urandom & 8'hfe;
         exp_q.push_back(b);
         xcvr.send(u, u == 0 ? {1'b1, b, 1'b0} : {2'b00, b}, u == 0 ? 10 : 8, 16);
         apb(0, `OFF_RXDATA, 0);
         chk("rx_byte", exp_q.pop_front(), rd);
      end
      $display("test receive done");
      apb(1, `OFF_CFG, 32'h0);
      for (u = 0; u < 2; u++) begin
         apb(1, `OFF_BITDIV, u ? 400 : 16);
         apb(1, `OFF_MODE, u ? `MODE_ASK : `MODE_SIR);
         b = $urandom;
         apb(1, `OFF_TXDATA, b);
         txcap(u ? 400 : 16, u ? `ASK_HALF : 0);
         chk("tx_byte", b, got);
         chk("tx_mark", u ? `ASK_HALF : 4, run);
         repeat (u ? 800 : 32) @(posedge pclk);
      end
      $display("test transmit done");
      apb(1, `OFF_BITDIV, 16);
      apb(1, `OFF_MODE, `MODE_SIR);
      apb(1, `OFF_HDTO, 3);
      apb(1, `OFF_CFG, 32'h02);
      b = $urandom;
      xcvr.send(0, {1'b1, b, 1'b0}, 10, 16);
      apb(1, `OFF_TXDATA, 32'h5a);
      txcap(16, 0);
      chk("hd_gap", 1, k >= 25);
      chk("hd_tx", 32'h5a, got);
      apb(0, `OFF_RXDATA, 0);
      chk("hd_rx", b, rd);
      $display("test turnaround done");
      close_out();
   end
endmodule
bind infrared_port_front_end irfe_chk chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
   .shared_pin_out(shared_pin_out), .shared_pin_oe(shared_pin_oe));
